//--- pkg/flash_host_pkg.sv
// Package: pin bundles, commands, timing counts for the flash bus host
package flash_host_pkg;
	localparam int unsigned CLOCK_MHZ = 20;
	localparam int unsigned CLOCK_PERIOD_NS = 50;
	// Wake-up times after power-down release (ns, plain defaults)
	localparam int unsigned WAKE_TO_OUTPUT_NS = 600;
	localparam int unsigned WAKE_TO_WRITE_NS = 600;
	localparam int unsigned WAKE_TO_OUTPUT_CYC =
		(WAKE_TO_OUTPUT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned WAKE_TO_WRITE_CYC =
		(WAKE_TO_WRITE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	// Bus strobe phase lengths in cycles
	localparam int unsigned ACCESS_CYC = 3;
	localparam int unsigned STROBE_LOW_CYC = 2;
	localparam int unsigned RECOVERY_CYC = 1;
	localparam logic [7:0] WAIT_MAX = 8'h00_FF;
	// Command codes
	localparam logic [7:0] CMD_READ_ARRAY = 8'h00_FF;
	localparam logic [7:0] CMD_IDENTIFY = 8'h00_90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h00_70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h00_50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h00_20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'h00_D0;
	localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h00_40;
	// Status layout
	localparam int unsigned SEQ_READY_BIT = 7;
	localparam logic [7:0] STATUS_AFTER_WAKE = 8'h00_80;
	localparam logic [16:0] ID_MFR_ADDR = 17'h0_0000;
	localparam logic [16:0] ID_DEV_ADDR = 17'h0_0001;

	// Host request operations
	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_WRITE = 3'h1,
		OP_PROGRAM = 3'h2,
		OP_ERASE = 3'h3,
		OP_POLL = 3'h4,
		OP_POWERDOWN = 3'h5,
		OP_WAKE = 3'h6
	} host_op_t;

	// Request from user side
	typedef struct packed {
		host_op_t op;
		logic [16:0] addr;
		logic [7:0] data;
		logic boot_unlock;
	} host_req_t;

	// Pins driven towards the flash
	typedef struct packed {
		logic chip_select_n;
		logic output_drive_n;
		logic write_strobe_n;
		logic powerdown_reset_n;
		logic boot_unlock_hv;
		logic program_supply_high;
		logic [16:0] addr;
		logic [7:0] data_out;
		logic data_oe;
	} flash_pins_t;
endpackage

//--- rtl/flash_bus_host.sv
// Host controller driving a byte-wide boot-block flash through its pins
//
// Behaviour
// - Program and erase are issued as two command writes when powered; unpowered, they end as errors with no write.
// - Read: select and output drive low, strobe and power-down high.
// - Host waits wake-to-output time before trusting read data.
// - Host waits wake-to-write time before any command write.
// - Boot block alteration needs boot-unlock high voltage held.
// - Drive power-down pin from wake and power-down requests; reset holds it low.
// - Writes with strobe and select low; captured on strobe rise.
`timescale 1ns/1ps
module flash_bus_host
	import flash_host_pkg::*;
(
	// Clock, reset, enable
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic enable_i,
	// User request
	input wire logic req_valid_i,
	input wire host_req_t req_i,
	output logic req_ready_o,
	// User answer
	output logic resp_valid_o,
	output logic [7:0] resp_data_o,
	output logic resp_error_o,
	// Flash pins
	input wire logic [7:0] data_lines_i,
	output flash_pins_t pins_o
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_CMD1 = 4'b0001,
		ST_CMD2 = 4'b0011,
		ST_POLL = 4'b0010,
		ST_DONE = 4'b0110,
		ST_WAKE = 4'b0111,
		ST_READ = 4'b0101
	} state_t;

	state_t state_reg, state_next;
	host_req_t cur_reg;
	flash_pins_t pins_next;
	logic [7:0] sync1_reg, sync2_reg;
	logic [7:0] wait_reg;
	logic [7:0] poll_reg;
	logic powered_reg;
	logic start_reg;
	logic is_write_reg;
	logic [7:0] wdata_reg;
	wire strobe_low, eng_busy, eng_done;
	wire [7:0] eng_data;
	wire accept;
	wire ready_bit;
	wire two_step;

	// Data pins cross from outside: two flops
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sync1_reg <= 8'h00_00;
			sync2_reg <= 8'h00_00;
		end else if (enable_i) begin
			sync1_reg <= data_lines_i;
			sync2_reg <= sync1_reg;
		end
	end

	flash_cycle_engine u_engine (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.enable_i(enable_i),
		.start_i(start_reg),
		.is_write_i(is_write_reg),
		.data_lines_sync_i(sync2_reg),
		.strobe_low_o(strobe_low),
		.busy_o(eng_busy),
		.done_o(eng_done),
		.rd_data_o(eng_data)
	);

	// Request decode
	assign accept = req_valid_i && req_ready_o;
	assign ready_bit = eng_data[SEQ_READY_BIT];
	assign two_step = (cur_reg.op == OP_PROGRAM) ||
		(cur_reg.op == OP_ERASE);

	// Sequencing of operations
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (accept) begin
					unique case (req_i.op)
						OP_READ: state_next = ST_READ;
						OP_POWERDOWN: state_next = ST_DONE;
						OP_WAKE: state_next = ST_WAKE;
						default: state_next = ST_CMD1;
					endcase
				end
			end
			ST_CMD1: if (eng_done)
				state_next = two_step ? ST_CMD2 : ST_DONE;
			ST_CMD2: if (eng_done) state_next = ST_POLL;
			ST_POLL: if (eng_done && (ready_bit || poll_reg == WAIT_MAX))
				state_next = ST_DONE;
			ST_READ: if (eng_done) state_next = ST_DONE;
			ST_WAKE: if (wait_reg == 8'h00_00) state_next = ST_DONE;
			ST_DONE: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// Pin values for the next cycle
	always_comb begin
		pins_next = pins_o;
		pins_next.powerdown_reset_n = powered_reg;
		pins_next.chip_select_n = !strobe_low;
		pins_next.output_drive_n = !(strobe_low && !is_write_reg);
		pins_next.write_strobe_n = !(strobe_low && is_write_reg);
		pins_next.data_oe = eng_busy && is_write_reg;
		pins_next.data_out = wdata_reg;
		pins_next.addr = cur_reg.addr;
		pins_next.program_supply_high = two_step &&
			(state_reg != ST_IDLE);
		pins_next.boot_unlock_hv = two_step && cur_reg.boot_unlock &&
			(state_reg != ST_IDLE);
	end

	// State and request registers
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			cur_reg <= '0;
			powered_reg <= 1'b0;
			wait_reg <= 8'h00_00;
			poll_reg <= 8'h00_00;
			start_reg <= 1'b0;
			is_write_reg <= 1'b0;
			wdata_reg <= 8'h00_00;
			req_ready_o <= 1'b0;
			resp_valid_o <= 1'b0;
			resp_data_o <= 8'h00_00;
			resp_error_o <= 1'b0;
			pins_o <= '{chip_select_n: 1'b1, output_drive_n: 1'b1,
				write_strobe_n: 1'b1, default: '0};
		end else if (enable_i) begin
			state_reg <= state_next;
			pins_o <= pins_next;
			start_reg <= 1'b0;
			resp_valid_o <= 1'b0;
			req_ready_o <= (state_next == ST_IDLE) && !req_valid_i;
			if (state_reg == ST_IDLE) req_ready_o <= 1'b0;
			if (state_next == ST_IDLE && state_reg != ST_IDLE)
				req_ready_o <= 1'b1;
			if (state_reg == ST_IDLE && !accept)
				req_ready_o <= 1'b1;
			if (accept) begin
				cur_reg <= req_i;
				unique case (req_i.op)
					OP_READ: begin
						start_reg <= powered_reg;
						is_write_reg <= 1'b0;
					end
					OP_WRITE: begin
						start_reg <= powered_reg;
						is_write_reg <= 1'b1;
						wdata_reg <= req_i.data;
					end
					OP_PROGRAM: begin
						start_reg <= powered_reg;
						is_write_reg <= 1'b1;
						wdata_reg <= CMD_PROGRAM_SETUP;
					end
					OP_ERASE: begin
						start_reg <= powered_reg;
						is_write_reg <= 1'b1;
						wdata_reg <= CMD_ERASE_SETUP;
					end
					OP_POLL: begin
						start_reg <= powered_reg;
						is_write_reg <= 1'b1;
						wdata_reg <= CMD_READ_STATUS;
					end
					OP_POWERDOWN: powered_reg <= 1'b0;
					OP_WAKE: begin
						powered_reg <= 1'b1;
						// Longer of the two wake times covers both
						wait_reg <= 8'((WAKE_TO_OUTPUT_CYC >
							WAKE_TO_WRITE_CYC) ? WAKE_TO_OUTPUT_CYC :
							WAKE_TO_WRITE_CYC);
					end
					default: start_reg <= 1'b0;
				endcase
			end
			if (state_reg == ST_WAKE && wait_reg != 8'h00_00)
				wait_reg <= wait_reg - 8'h01;
			// Second write of two-step commands
			if (state_reg == ST_CMD1 && eng_done && two_step) begin
				start_reg <= 1'b1;
				wdata_reg <= (cur_reg.op == OP_ERASE) ?
					CMD_ERASE_CONFIRM : cur_reg.data;
			end
			// Status polling until ready bit set or poll count reaches WAIT_MAX
			if (state_reg == ST_CMD2 && eng_done) begin
				start_reg <= 1'b1;
				is_write_reg <= 1'b0;
				poll_reg <= 8'h00_00;
			end
			if (state_reg == ST_POLL && eng_done && state_next == ST_POLL) begin
				start_reg <= 1'b1;
				poll_reg <= poll_reg + 8'h01;
			end
			if (state_next == ST_DONE && state_reg != ST_DONE) begin
				resp_data_o <= eng_data;
				resp_error_o <= (!powered_reg &&
					cur_reg.op != OP_POWERDOWN) ||
					(state_reg == ST_POLL && !ready_bit);
			end
			if (state_reg == ST_DONE) resp_valid_o <= 1'b1;
			// Unpowered cycles finish at once as errors
			if (state_reg inside {ST_CMD1, ST_READ} && !eng_busy &&
				!start_reg && !powered_reg) begin
				state_reg <= ST_DONE;
				resp_error_o <= 1'b1;
			end
		end
	end

	// Writes only while selected and strobe low
	write_select_a: assert property (@(posedge clock_i) disable iff (rst_i)
		!pins_o.write_strobe_n |-> !pins_o.chip_select_n)
		else $error("write strobe without select");
	// Read and write strobes never overlap
	strobe_excl_a: assert property (@(posedge clock_i) disable iff (rst_i)
		!(!pins_o.write_strobe_n && !pins_o.output_drive_n))
		else $error("read and write strobes overlap");
	// Host never drives data while flash outputs
	bus_fight_a: assert property (@(posedge clock_i) disable iff (rst_i)
		!pins_o.output_drive_n |-> !pins_o.data_oe)
		else $error("bus contention");
	// No strobes while powered down
	pd_quiet_a: assert property (@(posedge clock_i) disable iff (rst_i)
		!pins_o.powerdown_reset_n |-> pins_o.chip_select_n)
		else $error("access during power-down");
	// Erase and program carry high supply
	supply_high_a: assert property (@(posedge clock_i) disable iff (rst_i)
		(state_reg == ST_CMD2 && !pins_o.write_strobe_n) |->
		pins_o.program_supply_high)
		else $error("alteration without high supply");
	// Boot unlock only during altering commands
	boot_unlock_a: assert property (@(posedge clock_i) disable iff (rst_i)
		pins_o.boot_unlock_hv |-> pins_o.program_supply_high)
		else $error("boot unlock outside alteration");
	// Wake waits at least the configured time
	wake_wait_a: assert property (@(posedge clock_i) disable iff (rst_i)
		(state_reg == ST_WAKE && wait_reg > 8'h01) |=>
		state_reg == ST_WAKE)
		else $error("wake wait cut short");
	// Second command follows the first
	two_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
		(state_reg == ST_CMD1 && eng_done && two_step && enable_i) |=>
		state_reg == ST_CMD2)
		else $error("second command write missing");
endmodule

//--- rtl/flash_cycle_engine.sv
// One strobed bus cycle (read or write) towards the flash
`timescale 1ns/1ps
module flash_cycle_engine
	import flash_host_pkg::*;
(
	// Clock and control
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic enable_i,
	// Cycle request
	input wire logic start_i,
	input wire logic is_write_i,
	input wire logic [7:0] data_lines_sync_i,
	// Strobe state and result
	output logic strobe_low_o,
	output logic busy_o,
	output logic done_o,
	output logic [7:0] rd_data_o
);
	logic [3:0] count_reg;
	logic [1:0] phase_reg;
	logic write_reg;
	wire phase_end;
	wire [3:0] phase_len;

	// Phase 1: strobe low; phase 2: recovery high
	assign phase_len = (phase_reg == 2'h1) ?
		(write_reg ? 4'(STROBE_LOW_CYC) : 4'(ACCESS_CYC)) :
		4'(RECOVERY_CYC);
	assign phase_end = (count_reg + 4'h1 >= phase_len);
	assign strobe_low_o = (phase_reg == 2'h1);
	assign busy_o = (phase_reg != 2'h0);

	// Phase sequencing
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			phase_reg <= 2'h0;
			count_reg <= 4'h0;
			write_reg <= 1'b0;
			done_o <= 1'b0;
			rd_data_o <= 8'h00_00;
		end else if (enable_i) begin
			done_o <= 1'b0;
			if (phase_reg == 2'h0) begin
				if (start_i) begin
					phase_reg <= 2'h1;
					count_reg <= 4'h0;
					write_reg <= is_write_i;
				end
			end else if (phase_end) begin
				count_reg <= 4'h0;
				if (phase_reg == 2'h1) begin
					phase_reg <= 2'h2;
				end else begin
					phase_reg <= 2'h0;
					done_o <= 1'b1;
					// Sync adds two cycles: take data at recovery end
					if (!write_reg)
						rd_data_o <= data_lines_sync_i;
				end
			end else begin
				count_reg <= count_reg + 4'h1;
			end
		end
	end
endmodule

//--- tb/flash_model.sv
// Behavioural boot-block flash on the far side of the host
`timescale 1ns/1ps
module flash_model
	import flash_host_pkg::*;
#(
	parameter int BUSY_CYC = 60, // Erase and program run time
	parameter logic [7:0] MFR_CODE = 8'h00_A5, // Arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h00_3C, // Arbitrary value
	parameter logic [16:0] BOOT_BASE = 17'h1_E000
)
(
	// Timing reference
	input wire logic clock_i,
	// Host pins and data lines
	input wire flash_pins_t pins_i,
	output logic [7:0] data_lines_o
);
	logic [7:0] mem [0:131071];
	logic [1:0] mode_reg = 2'h0; // Array mode at power-up
	logic [7:0] status_reg = 8'h00_80;
	logic [7:0] setup_reg = 8'h00_00;
	logic [7:0] lat_data;
	logic [16:0] lat_addr;
	logic [16:0] op_addr;
	logic [7:0] op_data;
	logic op_erase;
	logic strobe_prev;
	logic [7:0] last_drv = 8'h00_00;
	int busy_cnt = 0;
	int wake_cnt = 0;
	wire awake = pins_i.powerdown_reset_n;
	wire busy = busy_cnt > 0;
	wire selected = awake && !pins_i.chip_select_n;
	wire reading = selected && !pins_i.output_drive_n
		&& pins_i.write_strobe_n;
	wire valid_out = wake_cnt >= WAKE_TO_OUTPUT_CYC;
	wire [7:0] id_val = (pins_i.addr == ID_MFR_ADDR) ? MFR_CODE
		: (pins_i.addr == ID_DEV_ADDR) ? DEV_CODE : 8'h00_00;
	wire [7:0] rd_val = (busy || mode_reg == 2'h2) ? status_reg
		: (mode_reg == 2'h1) ? id_val : mem[pins_i.addr];
	wire locked = !pins_i.program_supply_high
		|| (lat_addr >= BOOT_BASE && !pins_i.boot_unlock_hv);
	wire wr_rise = strobe_prev === 1'b0 && pins_i.write_strobe_n === 1'b1;
	wire two_step = setup_reg == CMD_PROGRAM_SETUP
		|| (setup_reg == CMD_ERASE_SETUP && lat_data == CMD_ERASE_CONFIRM);

	// Floating lines show the inverse of the last byte
	assign data_lines_o = (reading && valid_out) ? rd_val : ~last_drv;

	// Blank array
	initial begin
		for (int i = 0; i < 131072; i++) begin
			mem[i] = 8'h00_FF;
		end
	end

	// Command latch, sequencer and power-down
	always @(negedge clock_i) begin
		strobe_prev <= pins_i.write_strobe_n;
		if (reading && valid_out) begin
			last_drv <= rd_val;
		end
		if (!pins_i.write_strobe_n && selected) begin
			lat_addr <= pins_i.addr; // Held until strobe rise
			lat_data <= pins_i.data_out;
		end
		if (!awake) begin
			if (busy) begin
				mem[op_addr] <= 8'h00_0F; // Partly altered
			end
			busy_cnt <= 0; // All stopped
			wake_cnt <= 0;
			mode_reg <= 2'h0;
			status_reg <= STATUS_AFTER_WAKE;
			setup_reg <= 8'h00_00;
		end else begin
			if (wake_cnt < WAKE_TO_WRITE_CYC + WAKE_TO_OUTPUT_CYC) begin
				wake_cnt <= wake_cnt + 1;
			end
			if (busy) begin
				busy_cnt <= busy_cnt - 1; // Runs on deselected
			end
			if (busy_cnt == 1) begin
				status_reg[SEQ_READY_BIT] <= 1'b1;
				if (op_erase) begin
					for (int i = 0; i < 4096; i++) begin
						mem[{op_addr[16:12], i[11:0]}] <= 8'h00_FF;
					end
				end else begin
					mem[op_addr] <= op_data;
				end
			end
			// Ignored while busy or too soon after wake
			if (wr_rise && !busy && wake_cnt >= WAKE_TO_WRITE_CYC) begin
				setup_reg <= lat_data;
				if (two_step) begin
					setup_reg <= 8'h00_00;
					mode_reg <= 2'h2;
					if (locked) begin
						status_reg <= status_reg | (op_is_prog() ? 8'h00_10 : 8'h00_20);
					end else begin
						busy_cnt <= BUSY_CYC;
						status_reg[SEQ_READY_BIT] <= 1'b0;
						op_erase <= !op_is_prog();
						op_addr <= lat_addr;
						op_data <= lat_data;
					end
				end else begin
					case (lat_data)
						CMD_READ_ARRAY: mode_reg <= 2'h0;
						CMD_IDENTIFY: mode_reg <= 2'h1;
						CMD_CLEAR_STATUS: status_reg <= status_reg & 8'h00_80;
						CMD_READ_STATUS: mode_reg <= 2'h2;
						CMD_ERASE_SETUP: mode_reg <= 2'h2;
						CMD_PROGRAM_SETUP: mode_reg <= 2'h2;
						default: ;
					endcase
				end
			end
		end
	end

	function automatic logic op_is_prog();
		return setup_reg == CMD_PROGRAM_SETUP;
	endfunction
endmodule

//--- tb/test_flash_bus_host.sv
// Self-checking bench for the flash bus host against the flash model
`timescale 1ns/1ps
module test_flash_bus_host
	import flash_host_pkg::*;
;
	localparam logic [7:0] MFR = 8'h00_A5; // Arbitrary value
	localparam logic [7:0] DEV = 8'h00_3C; // Arbitrary value
	localparam logic [7:0] Z = 8'h00_00;
	localparam logic [7:0] S = 8'h00_80;
	localparam logic [16:0] A = 17'h0_0100;
	localparam logic [16:0] B = 17'h1_E010;
	typedef struct packed {
		host_op_t op;
		logic [16:0] addr;
		logic [7:0] data;
		logic unlock;
		logic [7:0] exp;
		logic err;
	} row_t;
	logic clock_i;
	logic rst_i;
	logic req_valid_i;
	host_req_t req_i;
	logic req_ready_o;
	logic resp_valid_o;
	logic [7:0] resp_data_o;
	logic resp_error_o;
	logic [7:0] data_lines;
	flash_pins_t pins;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	row_t rows [25] = '{
		'{OP_READ, A, Z, 1'b0, Z, 1'b1}, // Before wake
		'{OP_WAKE, A, Z, 1'b0, Z, 1'b0},
		'{OP_WRITE, A, 8'h00_90, 1'b0, Z, 1'b0},
		'{OP_READ, 17'h0_0000, Z, 1'b0, MFR, 1'b0},
		'{OP_READ, 17'h0_0001, Z, 1'b0, DEV, 1'b0},
		'{OP_WRITE, A, 8'h00_FF, 1'b0, Z, 1'b0},
		'{OP_READ, A, Z, 1'b0, 8'h00_FF, 1'b0},
		'{OP_PROGRAM, A, 8'h00_5A, 1'b0, S, 1'b0},
		'{OP_WRITE, A, 8'h00_FF, 1'b0, Z, 1'b0},
		'{OP_WRITE, A, 8'h00_D0, 1'b0, Z, 1'b0}, // Stray confirm
		'{OP_READ, A, Z, 1'b0, 8'h00_5A, 1'b0},
		'{OP_ERASE, A, Z, 1'b0, S, 1'b0},
		'{OP_WRITE, A, 8'h00_FF, 1'b0, Z, 1'b0},
		'{OP_READ, A, Z, 1'b0, 8'h00_FF, 1'b0},
		'{OP_PROGRAM, B, 8'h00_33, 1'b0, 8'h00_90, 1'b0}, // Boot locked
		'{OP_WRITE, A, 8'h00_50, 1'b0, Z, 1'b0},
		'{OP_PROGRAM, B, 8'h00_33, 1'b1, S, 1'b0},
		'{OP_WRITE, A, 8'h00_FF, 1'b0, Z, 1'b0},
		'{OP_READ, B, Z, 1'b0, 8'h00_33, 1'b0},
		'{OP_POWERDOWN, A, Z, 1'b0, Z, 1'b0},
		'{OP_READ, A, Z, 1'b0, Z, 1'b1},
		'{OP_WAKE, A, Z, 1'b0, Z, 1'b0},
		'{OP_READ, B, Z, 1'b0, 8'h00_33, 1'b0}, // Array after wake
		'{OP_POLL, A, Z, 1'b0, Z, 1'b0},
		'{OP_READ, A, Z, 1'b0, S, 1'b0}
	};

	// Design and far-side flash
	flash_bus_host dut_u (.clock_i(clock_i), .rst_i(rst_i), .enable_i(1'b1),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
		.resp_error_o(resp_error_o), .data_lines_i(data_lines), .pins_o(pins));
	flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) model_u (.clock_i(clock_i),
		.pins_i(pins), .data_lines_o(data_lines));

	// Clock and hang guard
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic send(input row_t r);
		req_i = '{r.op, r.addr, r.data, r.unlock};
		req_valid_i = 1'b1;
		do @(posedge clock_i); while (req_ready_o !== 1'b1);
		#2 req_valid_i = 1'b0;
	endtask

	task automatic run_row(input row_t r);
		logic [7:0] d;
		logic e;
		d = Z;
		e = 1'bx;
		send(r);
		for (int i = 0; i < 20000; i++) begin
			@(posedge clock_i);
			#2;
			if (resp_valid_o === 1'b1) begin
				d = resp_data_o;
				e = resp_error_o;
				break;
			end
		end
		check({7'h00, e}, {7'h00, r.err}); // Error flag
		if (!r.err && r.op inside {OP_READ, OP_PROGRAM, OP_ERASE}) begin
			check(d, r.exp);
		end
	endtask

	// Reset with pins checked while it is held
	task automatic do_reset();
		#2 rst_i = 1'b1;
		repeat (5) @(posedge clock_i);
		#2 check({5'h00, pins.powerdown_reset_n, pins.chip_select_n,
			pins.write_strobe_n}, 8'h00_03); // Flash held off
		@(posedge clock_i);
		#2 rst_i = 1'b0;
	endtask

	task summarize();
		if (n_errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Table of ordinary cases, then reset in mid-program
	initial begin
		rst_i = 1'b1;
		req_valid_i = 1'b0;
		req_i = '0;
		do_reset();
		foreach (rows[i]) begin
			run_row(rows[i]);
		end
		send('{OP_PROGRAM, A, 8'h00_77, 1'b0, Z, 1'b0});
		repeat (30) @(posedge clock_i);
		do_reset();
		run_row('{OP_WAKE, A, Z, 1'b0, Z, 1'b0});
		run_row('{OP_POLL, A, Z, 1'b0, Z, 1'b0});
		run_row('{OP_READ, A, Z, 1'b0, S, 1'b0}); // Clean status
		summarize();
	end
endmodule
